/* File: shared/smp_cfg.svh */
// character codes and sizes for the program message parser
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH
`define SMP_NL       8'h0a
`define SMP_SPACE    8'h20
`define SMP_STAR     8'h2a
`define SMP_COLON    8'h3a
`define SMP_SEMI     8'h3b
`define SMP_QMARK    8'h3f
`define SMP_KW_MAX   12
`define SMP_KW_BITS  96
`define SMP_N_KW     26
`define SMP_ROOT     5'h00
`define SMP_SRC_NODE 5'h08
`endif

/* File: shared/smp_pkg.sv */
// types shared by the program message parser modules
package smp_pkg;
    typedef enum logic [2:0] {
        S_START,
        S_KEY,
        S_QUERY,
        S_ARG,
        S_COMMON,
        S_SKIP
    } smp_state_type;

    typedef struct packed {
        logic [95:0] text;
        logic [3:0]  len;
        logic [4:0]  parent;
        logic        long_only;
    } smp_kw_type;
endpackage

/* File: hw/smp_kw_match.sv */
// compares the collected keyword with one entry of the command tree
`timescale 1ns/100ps
`include "smp_cfg.svh"
module smp_kw_match (
    input  wire logic [95:0] key_in,       // upper-case chars, char 0 low
    input  wire logic [3:0]  key_len_in,   // chars collected
    input  wire logic [95:0] name_in,      // long form, right-justified
    input  wire logic [3:0]  name_len_in,  // long form length
    input  wire logic        long_only_in, // short form refused
    output logic             hit_out       // exact short or long form
);
    logic [3:0] short_len;
    logic [7:0] fourth;
    logic       prefix_eq;

    // short form length derived from the long form itself
    always_comb begin
        fourth = name_in[8*(name_len_in-4'h4) +: 8];
        if (name_len_in <= 4'h4) begin
            short_len = name_len_in;
        end else if (fourth == "A" || fourth == "E" || fourth == "I" ||
                     fourth == "O" || fourth == "U") begin
            short_len = 4'h3;
        end else begin
            short_len = 4'h4;
        end
    end

    always_comb begin
        prefix_eq = 1'b1;
        for (int i = 0; i < `SMP_KW_MAX; i++) begin
            if (i < 32'(key_len_in) && i < 32'(name_len_in)) begin
                if (key_in[8*i +: 8] !=
                    name_in[8*(32'(name_len_in)-1-i) +: 8]) begin
                    prefix_eq = 1'b0;
                end
            end
        end
    end

    // no partial abbreviation: length must equal one of the two forms
    assign hit_out = prefix_eq && (key_len_in == name_len_in ||
                     (!long_only_in && key_len_in == short_len));
endmodule

/* File: hw/smp_parser.sv */
// program message parser: splits units and walks the command tree
`timescale 1ns/100ps
`include "smp_cfg.svh"
// Functional notes
// - newline byte 0a ends the message
// - char with end-of-line indication also terminates
// - keywords up to four letters: whole word
// - longer: four letters, three if vowel fourth
// - only exact short or long form accepted
// - keyword letters compared without case
// - separator colon descends below previous keyword
// - question mark after keyword makes query
// - space-separated parameter streamed as argument
// - semicolon ends unit, starts next one
// - leading colon resets position to root
// - terminator returns position to root
// - after semicolon resolve at previous level
// - first unit always decoded from root
// - optional source keyword may be omitted
// - asterisk unit is a common command
// - root holds the eleven subsystem keywords
// - per-keyword flag refuses the short form
module smp_parser (
    input  wire logic       core_clk_in,     // system clock
    input  wire logic       rst_n_in,        // async reset, active low
    input  wire logic       char_valid_in,   // one character this cycle
    input  wire logic [7:0] char_data_in,    // received character
    input  wire logic       eol_in,          // end_of_line_indication
    output logic            unit_valid_out,  // message unit decoded
    output logic [4:0]      unit_node_out,   // final keyword node
    output logic            unit_query_out,  // unit is a query
    output logic            unit_common_out, // unit is a common command
    output logic            arg_valid_out,   // argument character
    output logic [7:0]      arg_data_out,    // argument character value
    output logic            msg_end_out,     // terminator seen
    output logic            error_out,       // syntax error
    output logic [4:0]      level_out        // current tree node
);
    ////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    wire        rst_n = rst_sync[1];
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    ////////////////////////////////////////////////////////////////////
    // command tree; node id of entry i is i+1, root is node 0
    function automatic smp_pkg::smp_kw_type kw_entry(input int i);
        smp_pkg::smp_kw_type e;
        e = '0;
        case (i)
            0:  e = '{"ABORT",        4'h5, 5'h00, 1'b1};
            1:  e = '{"CALIBRATE",    4'h9, 5'h00, 1'b0};
            2:  e = '{"DISPLAY",      4'h7, 5'h00, 1'b0};
            3:  e = '{"INITIATE",     4'h8, 5'h00, 1'b0};
            4:  e = '{"LIST",         4'h4, 5'h00, 1'b0};
            5:  e = '{"MEASURE",      4'h7, 5'h00, 1'b0};
            6:  e = '{"OUTPUT",       4'h6, 5'h00, 1'b0};
            7:  e = '{"SOURCE",       4'h6, 5'h00, 1'b0};
            8:  e = '{"STATUS",       4'h6, 5'h00, 1'b0};
            9:  e = '{"SYSTEM",       4'h6, 5'h00, 1'b0};
            10: e = '{"TRIGGER",      4'h7, 5'h00, 1'b0};
            11: e = '{"VOLTAGE",      4'h7, 5'h08, 1'b0};
            12: e = '{"CURRENT",      4'h7, 5'h08, 1'b0};
            13: e = '{"FUNCTION",     4'h8, 5'h08, 1'b0};
            14: e = '{"OPERATION",    4'h9, 5'h09, 1'b0};
            15: e = '{"PRESET",       4'h6, 5'h09, 1'b0};
            16: e = '{"QUESTIONABLE", 4'hc, 5'h09, 1'b0};
            17: e = '{"CONDITION",    4'h9, 5'h0f, 1'b0};
            18: e = '{"ENABLE",       4'h6, 5'h0f, 1'b0};
            19: e = '{"EVENT",        4'h5, 5'h0f, 1'b0};
            20: e = '{"VOLTAGE",      4'h7, 5'h06, 1'b0};
            21: e = '{"CURRENT",      4'h7, 5'h06, 1'b0};
            22: e = '{"LEVEL",        4'h5, 5'h0c, 1'b0};
            23: e = '{"IMMEDIATE",    4'h9, 5'h17, 1'b0};
            24: e = '{"TRIGGER",      4'h7, 5'h17, 1'b0};
            25: e = '{"MODE",         4'h4, 5'h0e, 1'b0};
            default: e = '0;
        endcase
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////
    smp_pkg::smp_state_type state_reg, state_next;
    logic [95:0] key_reg, key_next;
    logic [3:0]  len_reg, len_next;
    logic [4:0]  cur_reg, cur_next;
    logic [4:0]  pend_reg, pend_next;
    logic [4:0]  par_reg, par_next;
    logic        query_reg, query_next;
    logic        common_reg, common_next;
    logic        uv_reg, uv_next;
    logic [4:0]  un_reg, un_next;
    logic        uq_reg, uq_next;
    logic        uc_reg, uc_next;
    logic        av_reg, av_next;
    logic [7:0]  ad_reg, ad_next;
    logic        me_reg, me_next;
    logic        err_reg, err_next;
    ////////////////////////////////////////////////////////////////////
    wire       is_term  = char_valid_in &&
                          (char_data_in == `SMP_NL || eol_in);
    wire       is_lower = char_data_in >= "a" && char_data_in <= "z";
    wire [7:0] up_char  = is_lower ? char_data_in - 8'h20 : char_data_in;
    wire       is_alpha = up_char >= "A" && up_char <= "Z";
    wire       is_colon = char_data_in == `SMP_COLON;
    wire       is_semi  = char_data_in == `SMP_SEMI;
    wire       is_qmark = char_data_in == `SMP_QMARK;
    wire       is_space = char_data_in == `SMP_SPACE;
    wire       is_star  = char_data_in == `SMP_STAR;
    wire       unit_end = is_semi || is_term;
    wire       kw_end   = is_colon || is_qmark || is_space || unit_end;
    ////////////////////////////////////////////////////////////////////
    logic [`SMP_N_KW-1:0] hit_vec;
    logic                 hit_any;
    logic [4:0]           hit_idx;
    logic [4:0]           hit_node;
    logic [4:0]           hit_par;
    genvar g;
    generate
        for (g = 0; g < `SMP_N_KW; g++) begin : g_kw
            wire smp_pkg::smp_kw_type ent = kw_entry(g);
            wire name_hit;
            // source is optional: its children answer at root and back
            wire par_ok = ent.parent == cur_reg ||
                (cur_reg == `SMP_ROOT && ent.parent == `SMP_SRC_NODE) ||
                (cur_reg == `SMP_SRC_NODE && ent.parent == `SMP_ROOT);
            smp_kw_match u_match (
                .key_in       (key_reg),
                .key_len_in   (len_reg),
                .name_in      (ent.text),
                .name_len_in  (ent.len),
                .long_only_in (ent.long_only),
                .hit_out      (name_hit)
            );
            assign hit_vec[g] = name_hit && par_ok;
        end
    endgenerate
    always_comb begin
        hit_any = 1'b0;
        hit_idx = 5'h00;
        for (int k = `SMP_N_KW - 1; k >= 0; k--) begin
            if (hit_vec[k]) begin
                hit_any = 1'b1;
                hit_idx = 5'(k);
            end
        end
    end
    assign hit_node = hit_idx + 5'h01;
    assign hit_par  = kw_entry(32'(hit_idx)).parent;
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next  = state_reg;
        key_next    = key_reg;
        len_next    = len_reg;
        cur_next    = cur_reg;
        pend_next   = pend_reg;
        par_next    = par_reg;
        query_next  = query_reg;
        common_next = common_reg;
        uv_next     = 1'b0;
        un_next     = pend_reg;
        uq_next     = query_reg;
        uc_next     = common_reg;
        av_next     = 1'b0;
        ad_next     = ad_reg;
        me_next     = 1'b0;
        err_next    = 1'b0;
        if (char_valid_in) begin
            case (state_reg)
                smp_pkg::S_START: begin
                    if (is_term || is_space) begin
                        state_next = smp_pkg::S_START;
                    end else if (is_star) begin
                        common_next = 1'b1;
                        state_next  = smp_pkg::S_COMMON;
                    end else if (is_colon) begin
                        cur_next   = `SMP_ROOT;
                        state_next = smp_pkg::S_KEY;
                    end else if (is_alpha) begin
                        key_next[7:0] = up_char;
                        len_next      = 4'h1;
                        state_next    = smp_pkg::S_KEY;
                    end else begin
                        err_next = 1'b1;
                    end
                end
                smp_pkg::S_KEY: begin
                    if (is_alpha && !is_term) begin
                        if (len_reg == 4'(`SMP_KW_MAX)) begin
                            err_next = 1'b1;
                        end else begin
                            key_next[8*len_reg +: 8] = up_char;
                            len_next = len_reg + 4'h1;
                        end
                    end else if (kw_end && len_reg == 4'h0) begin
                        // spaces may follow a colon before the keyword
                        err_next = !is_space;
                    end else if (kw_end && !hit_any) begin
                        err_next = 1'b1;
                    end else if (kw_end) begin
                        len_next  = 4'h0;
                        pend_next = hit_node;
                        par_next  = hit_par;
                        if (is_colon) begin
                            cur_next = hit_node;
                        end else if (is_qmark) begin
                            query_next = 1'b1;
                            state_next = smp_pkg::S_QUERY;
                        end else if (is_space) begin
                            state_next = smp_pkg::S_ARG;
                        end else begin
                            uv_next    = 1'b1;
                            un_next    = hit_node;
                            cur_next   = hit_par;
                            state_next = smp_pkg::S_START;
                        end
                    end else begin
                        err_next = 1'b1;
                    end
                end
                smp_pkg::S_QUERY: begin
                    if (unit_end) begin
                        uv_next    = 1'b1;
                        cur_next   = par_reg;
                        state_next = smp_pkg::S_START;
                    end else if (is_space) begin
                        state_next = smp_pkg::S_ARG;
                    end else begin
                        err_next = 1'b1;
                    end
                end
                smp_pkg::S_ARG, smp_pkg::S_COMMON: begin
                    if (unit_end) begin
                        uv_next    = 1'b1;
                        state_next = smp_pkg::S_START;
                        if (!common_reg) begin
                            cur_next = par_reg;
                        end
                    end else begin
                        av_next = 1'b1;
                        ad_next = char_data_in;
                    end
                end
                default: begin
                    state_next = smp_pkg::S_SKIP;
                end
            endcase
            if (uv_next) begin
                query_next  = 1'b0;
                common_next = 1'b0;
            end
            if (is_term) begin
                me_next    = 1'b1;
                cur_next   = `SMP_ROOT;
                len_next   = 4'h0;
                state_next = smp_pkg::S_START;
            end
            if (err_next) begin
                uv_next     = 1'b0;
                av_next     = 1'b0;
                len_next    = 4'h0;
                query_next  = 1'b0;
                common_next = 1'b0;
                state_next  = is_term ? smp_pkg::S_START : smp_pkg::S_SKIP;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= smp_pkg::S_START;
            key_reg    <= '0;
            len_reg    <= 4'h0;
            cur_reg    <= `SMP_ROOT;
            pend_reg   <= 5'h00;
            par_reg    <= 5'h00;
            query_reg  <= 1'b0;
            common_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            key_reg    <= key_next;
            len_reg    <= len_next;
            cur_reg    <= cur_next;
            pend_reg   <= pend_next;
            par_reg    <= par_next;
            query_reg  <= query_next;
            common_reg <= common_next;
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            {uv_reg, un_reg, uq_reg, uc_reg} <= '0;
            {av_reg, ad_reg, me_reg, err_reg} <= '0;
        end else begin
            {uv_reg, un_reg, uq_reg, uc_reg} <=
                {uv_next, un_next, uq_next, uc_next};
            {av_reg, ad_reg, me_reg, err_reg} <=
                {av_next, ad_next, me_next, err_next};
        end
    end
    assign unit_valid_out  = uv_reg;
    assign unit_node_out   = un_reg;
    assign unit_query_out  = uq_reg;
    assign unit_common_out = uc_reg;
    assign arg_valid_out   = av_reg;
    assign arg_data_out    = ad_reg;
    assign msg_end_out     = me_reg;
    assign error_out       = err_reg;
    assign level_out       = cur_reg;
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);
    sequence s_key_ok;
        char_valid_in && state_reg == smp_pkg::S_KEY && hit_any &&
        len_reg != 4'h0 && !is_term;
    endsequence
    sequence s_skip_then_term;
        state_reg == smp_pkg::S_SKIP ##1 is_term;
    endsequence
    chk_nl_ends_msg: assert property (
        char_valid_in && char_data_in == `SMP_NL |=> msg_end_out)
        else $error("newline did not end the message");
    chk_eol_ends_msg: assert property (
        char_valid_in && eol_in |=> msg_end_out && level_out == 5'h00)
        else $error("end-of-line char did not terminate");
    chk_term_root: assert property (
        msg_end_out |-> level_out == `SMP_ROOT &&
        state_reg == smp_pkg::S_START)
        else $error("terminator left parser away from root");
    chk_colon_descend: assert property (
        s_key_ok ##0 is_colon |=> level_out == $past(hit_node) &&
        !unit_valid_out)
        else $error("keyword separator did not descend");
    chk_root_spec: assert property (
        char_valid_in && is_colon && !eol_in && state_reg == smp_pkg::S_START
        |=> level_out == `SMP_ROOT && state_reg == smp_pkg::S_KEY)
        else $error("root specifier did not reset position");
    chk_semi_sibling: assert property (
        s_key_ok ##0 is_semi |=> unit_valid_out &&
        level_out == $past(hit_par) && unit_node_out == $past(hit_node))
        else $error("semicolon did not keep sibling level");
    chk_query_flag: assert property (
        s_key_ok ##0 is_qmark ##1 (char_valid_in && is_semi)
        |=> unit_valid_out && unit_query_out)
        else $error("query mark not reported on the unit");
    chk_common_unit: assert property (
        char_valid_in && state_reg == smp_pkg::S_COMMON && unit_end
        |=> unit_valid_out && unit_common_out)
        else $error("asterisk unit not reported as common");
    chk_miss_error: assert property (
        char_valid_in && state_reg == smp_pkg::S_KEY && kw_end &&
        !hit_any && len_reg != 4'h0 |=> error_out && !unit_valid_out)
        else $error("unknown keyword not flagged");
    chk_skip_resume: assert property (
        s_skip_then_term |=> state_reg == smp_pkg::S_START &&
        msg_end_out && !error_out)
        else $error("error skip did not resume at terminator");
endmodule

/* File: tb/smp_host_model.sv */
// host model: sends program messages one character per clock
`timescale 1ns/100ps
`include "smp_cfg.svh"
module smp_host_model (
    input  wire logic       core_clk_in,    // system clock
    output logic            char_valid_out, // character strobe
    output logic [7:0]      char_data_out,  // character value
    output logic            eol_out         // end_of_line_indication
);
    initial begin
        char_valid_out = 1'b0;
        char_data_out  = 8'h00;
        eol_out        = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic put(input logic [7:0] c, input logic e);
        @(posedge core_clk_in);
        #1;
        char_valid_out = 1'b1;
        char_data_out  = c;
        eol_out        = e;
    endtask

    // whole message in one go, units and colons exactly as given
    task automatic send(input string s, input bit eol_end);
        for (int i = 0; i < s.len(); i++) begin
            put(s[i], 1'b0);
        end
        if (eol_end) begin
            put(8'h58, 1'b1);
        end else begin
            put(`SMP_NL, 1'b0);
        end
        @(posedge core_clk_in);
        #1;
        char_valid_out = 1'b0;
        eol_out        = 1'b0;
        // idle line shows a changed byte so stale data is never reused
        char_data_out  = ~char_data_out;
    endtask
endmodule

/* File: tb/smp_parser_tb_top.sv */
// self-checking bench for the program message parser
`timescale 1ns/100ps
`define SMP_EQ(a, b, m) compare((a) == (b), m)
module smp_parser_tb_top;
    logic        core_clk_in;
    logic        rst_n_in;
    logic        char_valid_in;
    logic [7:0]  char_data_in;
    logic        eol_in;
    logic        unit_valid_out;
    logic [4:0]  unit_node_out;
    logic        unit_query_out;
    logic        unit_common_out;
    logic        arg_valid_out;
    logic [7:0]  arg_data_out;
    logic        msg_end_out;
    logic        error_out;
    logic [4:0]  level_out;
    int          fails;
    int          checks;
    int          n_end;
    int          n_err;
    logic [6:0]  units[$];
    string       args;
    logic [4:0]  end_level;

    smp_host_model host (.core_clk_in(core_clk_in),
        .char_valid_out(char_valid_in), .char_data_out(char_data_in),
        .eol_out(eol_in));
    smp_parser dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .char_valid_in(char_valid_in), .char_data_in(char_data_in),
        .eol_in(eol_in), .unit_valid_out(unit_valid_out),
        .unit_node_out(unit_node_out), .unit_query_out(unit_query_out),
        .unit_common_out(unit_common_out), .arg_valid_out(arg_valid_out),
        .arg_data_out(arg_data_out), .msg_end_out(msg_end_out),
        .error_out(error_out), .level_out(level_out));

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs read before the edge's own updates land
    always @(posedge core_clk_in) begin
        if (unit_valid_out === 1'b1)
            units.push_back({unit_common_out, unit_query_out, unit_node_out});
        if (arg_valid_out === 1'b1)
            args = {args, string'(arg_data_out)};
        if (msg_end_out === 1'b1) begin
            n_end++;
            end_level = level_out;
        end
        if (error_out === 1'b1)
            n_err++;
    end

    task automatic compare(input bit ok, input string m);
        checks++;
        if (!ok) begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [6:0] u(input logic [4:0] n, input logic q);
        return {1'b0, q, n};
    endfunction

    task automatic exchange(input string s, input bit eol_end);
        units.delete();
        args  = "";
        n_end = 0;
        n_err = 0;
        host.send(s, eol_end);
        repeat (3) @(posedge core_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_query_sibling();
        exchange("VOLT?;CURR", 1'b0);
        `SMP_EQ(units.size(), 2, "unit count");
        `SMP_EQ(units[0], u(5'h0c, 1'b1), "first unit");
        `SMP_EQ(units[1], u(5'h0d, 1'b0), "sibling unit");
        `SMP_EQ(n_end, 1, "one message end");
        `SMP_EQ(end_level, 5'h00, "level after end");
        $display("test query_sibling done");
    endtask

    task automatic t_paths();
        exchange("MEAS:VOLT 5", 1'b0);
        `SMP_EQ(units[0], u(5'h15, 1'b0), "measure path");
        `SMP_EQ(args, "5", "argument");
        exchange("stat:Oper:COND?;enab 16", 1'b0);
        `SMP_EQ(units[0], u(5'h12, 1'b1), "mixed case path");
        `SMP_EQ(units[1], u(5'h13, 1'b0), "deep sibling");
        `SMP_EQ(args, "16", "sibling argument");
        exchange("VOLT 15;:MEAS:CURR?", 1'b0);
        `SMP_EQ(units[1], u(5'h16, 1'b1), "root specifier");
        $display("test paths done");
    endtask

    task automatic t_common_eol();
        exchange("*RST", 1'b0);
        `SMP_EQ(units[0][6:5], 2'b10, "common unit");
        `SMP_EQ(args, "RST", "common header");
        exchange("*CLS;VOLT 3", 1'b0);
        `SMP_EQ(units[0][6:5], 2'b10, "common then unit");
        `SMP_EQ(units[1], u(5'h0c, 1'b0), "unit after common");
        `SMP_EQ(args, "CLS3", "common and argument");
        exchange("TRIG", 1'b1);
        `SMP_EQ(units[0], u(5'h0b, 1'b0), "eol ends unit");
        `SMP_EQ(n_end, 1, "eol message end");
        $display("test common_eol done");
    endtask

    task automatic t_root_names();
        string lf[11] = '{"ABORT", "CALIBRATE", "DISPLAY", "INITIATE",
            "LIST", "MEASURE", "OUTPUT", "SOURCE", "STATUS", "SYSTEM",
            "TRIGGER"};
        string sf[11] = '{"", "CAL", "DISP", "INIT", "LIST", "MEAS",
            "OUTP", "SOUR", "STAT", "SYST", "TRIG"};
        for (int i = 0; i < 11; i++) begin
            exchange((i % 2) ? {":", lf[i]} : lf[i], 1'b0);
            `SMP_EQ(units[0], u(5'(i + 1), 1'b0), lf[i]);
            if (i > 0) begin
                exchange(sf[i], 1'b0);
                `SMP_EQ(units[0], u(5'(i + 1), 1'b0), sf[i]);
            end
        end
        $display("test root_names done");
    endtask

    task automatic t_refused();
        string bad[5] = '{"ABOR", "LIS", "VOLT:LEV:IMME", "MEASU",
            "OUTPU:X 7;TRIG"};
        for (int i = 0; i < 5; i++) begin
            exchange(bad[i], 1'b0);
            `SMP_EQ(n_err, 1, bad[i]);
            `SMP_EQ(units.size(), 0, "no unit on error");
            `SMP_EQ(args, "", "no argument after error");
            `SMP_EQ(n_end, 1, "end after error");
        end
        exchange("VOLT:LEV:IMM", 1'b0);
        `SMP_EQ(units[0], u(5'h18, 1'b0), "resume at root");
        `SMP_EQ(n_err, 0, "clean after resume");
        $display("test refused done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails    = 0;
        checks   = 0;
        rst_n_in = 1'b0;
        repeat (10) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        repeat (4) @(posedge core_clk_in);
        t_query_sibling();
        t_paths();
        t_common_eol();
        t_root_names();
        t_refused();
        conclude();
    end

    // all tests take well under 1500 cycles
    initial begin
        #100us;
        fails++;
        conclude();
    end
endmodule
